//--- core/ish_pkg.sv
// Constants, carrier types and states of the two-wire slave hold/transmit engine.
// Assumes a system clock domain for software and a separate link clock for the pins.
//
// What this block does
// [RL1] Address hold: flag and clock hold after bit eight.
// [RL2] Data hold: flag and clock hold after bit eight.
// [RL3] Ack phase flag tells event before ack.
// [RL4] Held ack drives software chosen value, resumes on release.
// [RL5] Receive: flag after ninth fall only if acked.
// [RL6] Stretch enable holds clock after each ack.
// [RL7] Stop is recorded in a pollable stop bit.
// [RL8] Read address: set direction, load buffer, ack.
// [RL9] After read address ack, hold until release.
// [RL10] Buffer write loads shifter; bits change on falls.
// [RL11] Master ack latched on ninth rise; nack idles.
// [RL12] Transmit: flag every ninth fall; hold only acked.
// [RL13] Transmit collision sets flag and returns idle.
// [RL14] Transmit address hold: event before the ack.
// [RL15] Transmit address hold: second event after ack.
// [RL16] Transmit writes accepted only after address ack or master ack.
// [RL17] Master nacks last read byte before stop.
// [RL18] Ten-bit high write match: update flag, hold.
// [RL19] Own address write releases clock after ack.
// [RL20] Low byte mismatch: flag, update flag, no load.
// [RL21] Ten-bit data with stretch holds each byte.
// [RL22] Reading the buffer clears the full flag.
// [RL23] Ten-bit high byte compares 11110, A9, A8.
// [RL24] Seven-bit compare ignores the direction bit.
// [RL25] Nack an address while full or overflowed.
// [RL26] Both lines are driven only pull-low.
`default_nettype none
package ish_pkg;

  // ---------------------------------------------------------------
  // Byte framing and address patterns
  // ---------------------------------------------------------------
  localparam logic [3:0] BYTE_DONE = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [4:0] TEN_HI_PAT = 5'h1e;
  localparam int UPPER_MSB = 2;
  localparam int UPPER_LSB = 1;

  // Ten-bit address progress.
  localparam logic [1:0] TB_NONE = 2'h0;
  localparam logic [1:0] TB_LOW = 2'h1;
  localparam logic [1:0] TB_FULL = 2'h2;

  // Reset values.
  localparam logic RELEASE_RST = 1'h1;
  localparam logic LINE_HIGH = 1'h1;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_AACK, L_RX, L_RACK, L_TX, L_TACK} ish_st_t;

  // Configuration handed from the system domain to the link domain.
  typedef struct packed {
    logic ce;
    logic ahold;
    logic dhold;
    logic stretch;
    logic ten;
    logic ackv;
    logic coll_en;
    logic full;
    logic [7:0] own;
  } ish_cfg_t;

  // One event word handed from the link domain to the system domain.
  typedef struct packed {
    logic flag;
    logic ckclr;
    logic ackset;
    logic ackclr;
    logic load;
    logic addr_upd;
    logic rw_upd;
    logic rw;
    logic ovf;
    logic stop;
    logic coll;
    logic rack_upd;
    logic rack;
    logic txok;
    logic fullclr;
    logic [7:0] data;
  } ish_ev_t;

  localparam ish_ev_t EV_NONE = '0;
  localparam ish_cfg_t CFG_RST = '0;

endpackage
`default_nettype wire

//--- core/ish_engine.sv
// Two-wire slave engine: pin logic on the link clock, software flags on CLOCK.
// Assumes the bus master keeps protocol timing and that SCL is slow against LINK_CLK.
`timescale 1ns/1ns
`default_nettype none
module ish_engine (
  // Clocks and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic LINK_CLK,
  // Configuration levels
  input wire logic ADDRESS_HOLD_ENABLE,
  input wire logic DATA_HOLD_ENABLE,
  input wire logic STRETCH_ENABLE,
  input wire logic TEN_BIT_ENABLE,
  input wire logic ACK_VALUE_SELECT,
  input wire logic SLAVE_COLLISION_DETECT_ENABLE,
  // Software strobes
  input wire logic EVENT_CLR,
  input wire logic RELEASE_SET,
  input wire logic SHIFT_BUFFER_WR,
  input wire logic [7:0] SHIFT_BUFFER_WDATA,
  input wire logic SHIFT_BUFFER_RD,
  input wire logic OWN_ADDRESS_WR,
  input wire logic [7:0] OWN_ADDRESS_WDATA,
  input wire logic OVERFLOW_CLR,
  input wire logic STOP_CLR,
  input wire logic COLLISION_CLR,
  // Status
  output logic SERIAL_EVENT_FLAG,
  output logic CLOCK_RELEASE_BIT,
  output logic ACK_PHASE_FLAG,
  output logic REMOTE_ACK_STATUS,
  output logic BUFFER_FULL_FLAG,
  output logic RECEIVE_OVERFLOW_FLAG,
  output logic ADDRESS_UPDATE_FLAG,
  output logic READ_WRITE_STATUS,
  output logic STOP_SEEN,
  output logic COLLISION_FLAG,
  output logic [7:0] SHIFT_BUFFER_RDATA,
  // Bus pins
  input wire logic SCL_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  ish_pkg::ish_cfg_t cfg_q, cfg_m, cfg_l;
  ish_pkg::ish_ev_t ev_q;
  ish_pkg::ish_st_t st_q;
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  logic [2:0] tg_q, tg_m, tg_s, tg_p;
  logic evt_q, evt_m, evt_s, evt_p;
  logic [3:0] cnt_q;
  logic [7:0] sr_q, tx_q, tx_data_q, buf_q;
  logic [1:0] tb_q;
  logic hold_q, h8_q, uh_q, nack_q, ovf_q, ld_q, rw_q, au_q, rack_q, sda_oe_q, scl_oe_q;
  logic flag_q, rel_q, ackph_q, rack_st_q, full_q, ovf_st_q, upd_q, rwst_q, stop_q, coll_q, txok_q;
  logic [7:0] own_q;

  // ---------------------------------------------------------------
  // Link domain: pin and crossing synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_m <= ish_pkg::LINE_HIGH;
      scl_s <= ish_pkg::LINE_HIGH;
      scl_p <= ish_pkg::LINE_HIGH;
      sda_m <= ish_pkg::LINE_HIGH;
      sda_s <= ish_pkg::LINE_HIGH;
      sda_p <= ish_pkg::LINE_HIGH;
      tg_m <= 3'h0;
      tg_s <= 3'h0;
      tg_p <= 3'h0;
      cfg_m <= ish_pkg::CFG_RST;
      cfg_l <= ish_pkg::CFG_RST;
    end else begin
      scl_m <= SCL_I;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= SDA_I;
      sda_s <= sda_m;
      sda_p <= sda_s;
      tg_m <= tg_q;
      tg_s <= tg_m;
      tg_p <= tg_s;
      cfg_m <= cfg_q;
      cfg_l <= cfg_m;
    end
  end

  wire scl_rise = scl_s & ~scl_p;
  wire scl_fall = ~scl_s & scl_p;
  wire start_c = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_c = scl_s & scl_p & ~sda_p & sda_s;
  wire rel_ev = tg_s[0] ^ tg_p[0];
  wire upd_ev = tg_s[1] ^ tg_p[1];
  wire txl_ev = tg_s[2] ^ tg_p[2];
  // The transmit word is held still by software until its toggle has been seen here.
  wire [7:0] tx_now = txl_ev ? tx_data_q : tx_q;

  // ---------------------------------------------------------------
  // Link domain: address compare and acknowledge decision
  // ---------------------------------------------------------------
  wire is_addr = st_q == ish_pkg::L_ADDR;
  wire low = cfg_l.ten & (tb_q == ish_pkg::TB_LOW);
  wire [6:0] hi_pat = {ish_pkg::TEN_HI_PAT, cfg_l.own[ish_pkg::UPPER_MSB:ish_pkg::UPPER_LSB]}; // [RL23]
  wire m7 = sr_q[7:1] == cfg_l.own[7:1]; // [RL24]
  wire mhi = (sr_q[7:1] == hi_pat) & (~sr_q[0] | (tb_q == ish_pkg::TB_FULL));
  wire lmatch = sr_q == cfg_l.own;
  wire hit = ~is_addr | low | (cfg_l.ten ? mhi : m7);
  wire nk = cfg_l.full | (low & ~lmatch); // [RL25]
  wire hold8 = (is_addr ? cfg_l.ahold : cfg_l.dhold) & ~nk;

  // ---------------------------------------------------------------
  // Link domain: byte engine
  // ---------------------------------------------------------------
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= ish_pkg::L_IDLE;
      cnt_q <= ish_pkg::CNT_ZERO;
      sr_q <= ish_pkg::BYTE_RST;
      tx_q <= ish_pkg::BYTE_RST;
      tb_q <= ish_pkg::TB_NONE;
      {hold_q, h8_q, uh_q, nack_q, ovf_q, ld_q, rw_q, au_q, rack_q, sda_oe_q} <= 10'h000;
      ev_q <= ish_pkg::EV_NONE;
      evt_q <= 1'h0;
    end else if (cfg_l.ce) begin
      if (txl_ev) tx_q <= tx_data_q; // [RL10]
      if (start_c) begin
        st_q <= ish_pkg::L_ADDR;
        cnt_q <= ish_pkg::CNT_ZERO;
        {hold_q, h8_q, uh_q, sda_oe_q} <= 4'h0;
      end else if (stop_c) begin
        st_q <= ish_pkg::L_IDLE;
        tb_q <= ish_pkg::TB_NONE;
        {hold_q, h8_q, uh_q, sda_oe_q} <= 4'h0;
        ev_q <= ish_pkg::EV_NONE;
        ev_q.stop <= 1'h1; // [RL7]
        evt_q <= ~evt_q;
      end else if (hold_q) begin
        if (uh_q ? upd_ev : rel_ev) begin // [RL19]
          hold_q <= 1'h0;
          uh_q <= 1'h0;
          h8_q <= 1'h0;
          if (h8_q) begin
            nack_q <= cfg_l.ackv; // [RL4]
            sda_oe_q <= ~cfg_l.ackv;
          end else if (st_q == ish_pkg::L_TX) begin
            sda_oe_q <= ~tx_now[7];
          end
        end
      end else begin
        case (st_q)
          ish_pkg::L_ADDR, ish_pkg::L_RX: begin
            if (scl_rise) begin
              sr_q <= {sr_q[6:0], sda_s};
              cnt_q <= cnt_q + ish_pkg::CNT_ONE;
            end else if (scl_fall && cnt_q == ish_pkg::BYTE_DONE) begin
              if (!hit) begin
                st_q <= ish_pkg::L_IDLE;
                tb_q <= ish_pkg::TB_NONE;
              end else begin
                st_q <= is_addr ? ish_pkg::L_AACK : ish_pkg::L_RACK;
                rw_q <= is_addr & ~low & sr_q[0];
                au_q <= is_addr & cfg_l.ten & (low | ~sr_q[0]);
                nack_q <= nk;
                ovf_q <= cfg_l.full;
                ld_q <= hold8;
                if (hold8) begin
                  hold_q <= 1'h1; // [RL1] [RL2] [RL14]
                  h8_q <= 1'h1;
                  ev_q <= ish_pkg::EV_NONE;
                  ev_q.flag <= 1'h1;
                  ev_q.ckclr <= 1'h1;
                  ev_q.ackset <= 1'h1; // [RL3]
                  ev_q.load <= 1'h1;
                  ev_q.data <= sr_q;
                  ev_q.rw_upd <= is_addr;
                  ev_q.rw <= is_addr & ~low & sr_q[0];
                  evt_q <= ~evt_q;
                end else begin
                  sda_oe_q <= ~nk; // [RL8] [RL26]
                end
              end
            end
          end
          ish_pkg::L_AACK, ish_pkg::L_RACK: begin
            if (scl_fall) begin
              sda_oe_q <= 1'h0;
              cnt_q <= ish_pkg::CNT_ZERO;
              ev_q <= ish_pkg::EV_NONE;
              ev_q.flag <= ~nack_q | au_q; // [RL5] [RL20]
              ev_q.ackclr <= 1'h1;
              ev_q.load <= ~nack_q & ~ld_q;
              ev_q.data <= sr_q;
              ev_q.addr_upd <= au_q; // [RL18]
              ev_q.ovf <= ovf_q;
              ev_q.rw_upd <= st_q == ish_pkg::L_AACK;
              ev_q.rw <= rw_q;
              ev_q.txok <= ~nack_q & rw_q; // [RL16]
              evt_q <= ~evt_q;
              if (au_q) begin
                hold_q <= 1'h1;
                uh_q <= 1'h1;
                if (!low) begin
                  st_q <= ish_pkg::L_ADDR;
                  tb_q <= ish_pkg::TB_LOW;
                end else begin
                  st_q <= nack_q ? ish_pkg::L_IDLE : ish_pkg::L_RX;
                  tb_q <= nack_q ? ish_pkg::TB_NONE : ish_pkg::TB_FULL;
                end
              end else if (nack_q) begin
                st_q <= ish_pkg::L_IDLE;
              end else if (rw_q) begin
                hold_q <= 1'h1; // [RL9] [RL15]
                ev_q.ckclr <= 1'h1;
                st_q <= ish_pkg::L_TX;
              end else begin
                st_q <= ish_pkg::L_RX;
                hold_q <= cfg_l.stretch; // [RL6] [RL21]
                ev_q.ckclr <= cfg_l.stretch;
              end
            end
          end
          ish_pkg::L_TX: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + ish_pkg::CNT_ONE;
              if (!sda_oe_q && !sda_s && cfg_l.coll_en) begin
                st_q <= ish_pkg::L_IDLE; // [RL13]
                ev_q <= ish_pkg::EV_NONE;
                ev_q.coll <= 1'h1;
                evt_q <= ~evt_q;
              end
            end else if (scl_fall) begin
              if (cnt_q == ish_pkg::BYTE_DONE) begin
                sda_oe_q <= 1'h0;
                st_q <= ish_pkg::L_TACK;
              end else begin
                tx_q <= {tx_q[6:0], 1'h0}; // [RL10]
                sda_oe_q <= ~tx_q[6];
              end
            end
          end
          ish_pkg::L_TACK: begin
            if (scl_rise) begin
              rack_q <= sda_s; // [RL11]
              ev_q <= ish_pkg::EV_NONE;
              ev_q.rack_upd <= 1'h1;
              ev_q.rack <= sda_s;
              evt_q <= ~evt_q;
            end else if (scl_fall) begin
              cnt_q <= ish_pkg::CNT_ZERO;
              ev_q <= ish_pkg::EV_NONE;
              ev_q.flag <= 1'h1; // [RL12]
              ev_q.fullclr <= 1'h1;
              ev_q.txok <= ~rack_q;
              ev_q.ckclr <= ~rack_q;
              evt_q <= ~evt_q;
              hold_q <= ~rack_q;
              st_q <= rack_q ? ish_pkg::L_IDLE : ish_pkg::L_TX; // [RL11] [RL17]
            end
          end
          default: begin
            st_q <= st_q;
          end
        endcase
      end
    end
  end

  // Holding only follows a falling edge, so SCL is already low when pulled.
  always_ff @(posedge LINK_CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_oe_q <= 1'h0;
    end else begin
      scl_oe_q <= hold_q; // [RL26]
    end
  end

  // ---------------------------------------------------------------
  // System domain: event receive and software registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      evt_m <= 1'h0;
      evt_s <= 1'h0;
      evt_p <= 1'h0;
    end else begin
      evt_m <= evt_q;
      evt_s <= evt_m;
      evt_p <= evt_s;
    end
  end

  wire ev_new = evt_s ^ evt_p;
  wire buf_ok = SHIFT_BUFFER_WR & txok_q; // [RL16]
  wire own_ok = OWN_ADDRESS_WR & ~ackph_q; // [RL19]

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      {flag_q, ackph_q, rack_st_q, full_q, ovf_st_q, upd_q, rwst_q, stop_q, coll_q, txok_q} <= 10'h000;
      rel_q <= ish_pkg::RELEASE_RST;
      buf_q <= ish_pkg::BYTE_RST;
      own_q <= ish_pkg::BYTE_RST;
      tx_data_q <= ish_pkg::BYTE_RST;
      tg_q <= 3'h0;
      cfg_q <= ish_pkg::CFG_RST;
    end else if (CE) begin
      flag_q <= (flag_q & ~EVENT_CLR) | (ev_new & ev_q.flag);
      ovf_st_q <= (ovf_st_q & ~OVERFLOW_CLR) | (ev_new & ev_q.ovf);
      stop_q <= (stop_q & ~STOP_CLR) | (ev_new & ev_q.stop); // [RL7]
      coll_q <= (coll_q & ~COLLISION_CLR) | (ev_new & ev_q.coll); // [RL13]
      upd_q <= (upd_q & ~own_ok) | (ev_new & ev_q.addr_upd);
      full_q <= (full_q & ~SHIFT_BUFFER_RD & ~(ev_new & ev_q.fullclr)) | (ev_new & ev_q.load) | buf_ok; // [RL22]
      txok_q <= (txok_q & ~buf_ok & ~(ev_new & (ev_q.stop | ev_q.coll))) | (ev_new & ev_q.txok);
      if (ev_new && ev_q.ckclr) rel_q <= 1'h0;
      else if (RELEASE_SET) rel_q <= 1'h1;
      if (ev_new && ev_q.ackset) ackph_q <= 1'h1;
      else if (ev_new && ev_q.ackclr) ackph_q <= 1'h0;
      if (ev_new && ev_q.rw_upd) rwst_q <= ev_q.rw;
      if (ev_new && ev_q.rack_upd) rack_st_q <= ev_q.rack;
      if (ev_new && ev_q.load) buf_q <= ev_q.data;
      else if (buf_ok) buf_q <= SHIFT_BUFFER_WDATA; // [RL10]
      if (buf_ok) tx_data_q <= SHIFT_BUFFER_WDATA;
      if (own_ok) own_q <= OWN_ADDRESS_WDATA;
      tg_q <= tg_q ^ {buf_ok, own_ok, RELEASE_SET};
      cfg_q <= '{ce: 1'h1, ahold: ADDRESS_HOLD_ENABLE, dhold: DATA_HOLD_ENABLE,
        stretch: STRETCH_ENABLE, ten: TEN_BIT_ENABLE, ackv: ACK_VALUE_SELECT,
        coll_en: SLAVE_COLLISION_DETECT_ENABLE, full: full_q | ovf_st_q,
        own: own_ok ? OWN_ADDRESS_WDATA : own_q};
    end else begin
      cfg_q.ce <= 1'h0;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign SERIAL_EVENT_FLAG = flag_q;
  assign CLOCK_RELEASE_BIT = rel_q;
  assign ACK_PHASE_FLAG = ackph_q;
  assign REMOTE_ACK_STATUS = rack_st_q;
  assign BUFFER_FULL_FLAG = full_q;
  assign RECEIVE_OVERFLOW_FLAG = ovf_st_q;
  assign ADDRESS_UPDATE_FLAG = upd_q;
  assign READ_WRITE_STATUS = rwst_q;
  assign STOP_SEEN = stop_q;
  assign COLLISION_FLAG = coll_q;
  assign SHIFT_BUFFER_RDATA = buf_q;
  assign SCL_O = 1'h0;
  assign SCL_OE = scl_oe_q;
  assign SDA_O = 1'h0;
  assign SDA_OE = sda_oe_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence held_s;
    hold_q ##1 scl_oe_q;
  endsequence

  addr_hold_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N) // [RL1]
    (cfg_l.ce && !hold_q && !start_c && !stop_c && scl_fall && is_addr && cnt_q == ish_pkg::BYTE_DONE
     && hit && hold8) |=> held_s ##0 ev_q.flag)
    else $error("address hold did not stretch");
  data_hold_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N) // [RL2]
    (cfg_l.ce && !hold_q && scl_fall && st_q == ish_pkg::L_RX && cnt_q == ish_pkg::BYTE_DONE
     && cfg_l.dhold && !nk) |=> held_s)
    else $error("data hold did not stretch");
  ack_value_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N) // [RL4]
    (cfg_l.ce && hold_q && h8_q && !uh_q && rel_ev && !start_c && !stop_c) |=> (sda_oe_q == !cfg_l.ackv) && !hold_q)
    else $error("held ack level wrong");
  rx_flag_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N) // [RL5]
    (cfg_l.ce && !hold_q && scl_fall && st_q == ish_pkg::L_RACK) |=> (ev_q.flag == !$past(nack_q)) && !sda_oe_q)
    else $error("receive flag mismatch");
  tx_stable_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N) // [RL10]
    (st_q == ish_pkg::L_TX && scl_s && $past(scl_s) && !$past(hold_q)) |-> $stable(sda_oe_q))
    else $error("transmit data moved while clock high");
  nack_idle_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N) // [RL11]
    (cfg_l.ce && !hold_q && scl_fall && st_q == ish_pkg::L_TACK && rack_q) |=> st_q == ish_pkg::L_IDLE ##1 !scl_oe_q)
    else $error("nack did not idle");
  tx_ack_hold_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N) // [RL12]
    (cfg_l.ce && !hold_q && scl_fall && st_q == ish_pkg::L_TACK && !rack_q) |=> ev_q.flag ##0 held_s)
    else $error("transmit ack hold missing");
  coll_idle_a: assert property (@(posedge LINK_CLK) disable iff (!RST_N) // [RL13]
    (cfg_l.ce && !hold_q && !start_c && !stop_c && scl_rise && st_q == ish_pkg::L_TX && !sda_oe_q && !sda_s
     && cfg_l.coll_en) |=> st_q == ish_pkg::L_IDLE && ev_q.coll)
    else $error("collision not handled");
  stop_seen_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RL7]
    (CE && ev_new && ev_q.stop) |=> STOP_SEEN)
    else $error("stop not recorded");
  buf_read_a: assert property (@(posedge CLOCK) disable iff (!RST_N) // [RL22]
    (CE && SHIFT_BUFFER_RD && !buf_ok && !(ev_new && ev_q.load)) |=> !BUFFER_FULL_FLAG)
    else $error("buffer read kept full flag");

endmodule
`default_nettype wire

//--- test/ish_master.sv
// Bus master model for the two-wire slave bench: START, byte transfers with acknowledge, STOP.
// Assumes both lines are pulled up and that the bench resolves the wired-AND of all pull-low enables.
`timescale 1ns/1ns
`default_nettype none
module ish_master (
  // Resolved line levels
  input wire logic scl,
  input wire logic sda,
  // Pull-low enables
  output logic scl_oe,
  output logic sda_oe
);
  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  // Six link clocks per phase keep each level well clear of the slave's two-stage sampling.
  localparam int Q = 480;

  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  // The wait for SCL high lets a stretching slave pause the bit, with a cap so a stuck line cannot hang.
  task automatic bit_io(input logic b, output logic r);
    sda_oe = !b;
    #Q;
    scl_oe = 1'b0;
    for (int i = 0; i < 5000 && scl !== 1'b1; i++) #10;
    #Q;
    r = sda;
    scl_oe = 1'b1;
    #Q;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(mack, ack);
  endtask

  task automatic start();
    sda_oe = 1'b1;
    #Q;
    scl_oe = 1'b1;
    #Q;
  endtask

  task automatic stop();
    sda_oe = 1'b1;
    #Q;
    scl_oe = 1'b0;
    #Q;
    sda_oe = 1'b0;
    #Q;
  endtask
endmodule
`default_nettype wire

//--- test/ish_engine_tb.sv
// Self-checking bench for the two-wire slave engine: software side by strobes, bus side by the master model.
// Assumes the engine's flags cross to CLOCK within a few cycles and the master keeps slow bit timing.
`timescale 1ns/1ns
`default_nettype none
module ish_engine_tb;
  logic clk, rst_n, link_clk;
  logic [5:0] cfg;
  logic [7:0] stb, wdat, rdata, rx;
  logic flag, rel, aph, rack, bf, ovf, ua, rw, stop_seen, coll, ack;
  logic scl_oe, sda_oe, m_scl_oe, m_sda_oe;
  int miscompares, comparisons, cycles;
  wire logic scl = !(scl_oe | m_scl_oe);
  wire logic sda = !(sda_oe | m_sda_oe);

  ish_engine DUT (.CLOCK(clk), .RST_N(rst_n), .CE(1'b1), .LINK_CLK(link_clk),
    .ADDRESS_HOLD_ENABLE(cfg[0]), .DATA_HOLD_ENABLE(cfg[1]), .STRETCH_ENABLE(cfg[2]),
    .TEN_BIT_ENABLE(cfg[3]), .ACK_VALUE_SELECT(cfg[4]), .SLAVE_COLLISION_DETECT_ENABLE(cfg[5]),
    .EVENT_CLR(stb[0]), .RELEASE_SET(stb[1]), .SHIFT_BUFFER_WR(stb[2]), .SHIFT_BUFFER_WDATA(wdat),
    .SHIFT_BUFFER_RD(stb[3]), .OWN_ADDRESS_WR(stb[4]), .OWN_ADDRESS_WDATA(wdat), .OVERFLOW_CLR(stb[5]),
    .STOP_CLR(stb[6]), .COLLISION_CLR(stb[7]), .SERIAL_EVENT_FLAG(flag), .CLOCK_RELEASE_BIT(rel),
    .ACK_PHASE_FLAG(aph), .REMOTE_ACK_STATUS(rack), .BUFFER_FULL_FLAG(bf), .RECEIVE_OVERFLOW_FLAG(ovf),
    .ADDRESS_UPDATE_FLAG(ua), .READ_WRITE_STATUS(rw), .STOP_SEEN(stop_seen), .COLLISION_FLAG(coll),
    .SHIFT_BUFFER_RDATA(rdata), .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(),
    .SDA_OE(sda_oe));
  ish_master m (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  initial begin
    link_clk = 1'b0;
    #7;
    forever #40 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      miscompares++;
      results();
    end
  end
  task automatic results();
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // The trailing step lets the strobed flag update land before anything is sampled.
  task automatic strobe(input int k, input logic [7:0] d);
    @(posedge clk);
    stb[k] <= 1'b1;
    wdat <= d;
    @(posedge clk);
    stb <= '0;
    #1;
  endtask
  task automatic settle();
    repeat (40) @(posedge clk);
    #1;
  endtask
  task automatic setcfg(input int k, input logic v);
    @(posedge clk);
    cfg[k] <= v;
    settle();
  endtask
  task automatic wait_ev();
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(flag, 1'b1);
    strobe(0, 8'h00);
  endtask
  task automatic tx(input logic [7:0] d, input logic mack);
    strobe(2, d);
    chk(bf, 1'b1);
    strobe(1, 8'h00);
    m.xfer(8'hff, mack, rx, ack);
    chk(rx, d);
    wait_ev();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_write();
    m.start();
    m.xfer(8'ha4, 1'b1, rx, ack);
    chk(ack, 1'b0);
    wait_ev();
    chk(rdata, 8'ha4);
    strobe(3, 8'h00);
    chk(bf, 1'b0);
    m.xfer(8'h5c, 1'b1, rx, ack);
    wait_ev();
    chk(rdata, 8'h5c);
    chk(rel, 1'b1);
    m.stop();
    settle();
    chk(stop_seen, 1'b1);
    m.start();
    m.xfer(8'ha4, 1'b1, rx, ack);
    chk(ack, 1'b1);
    settle();
    chk(flag, 1'b0);
    chk(ovf, 1'b1);
    m.stop();
    strobe(3, 8'h00);
    strobe(5, 8'h00);
    strobe(6, 8'h00);
  endtask

  task automatic t_hold();
    setcfg(0, 1'b1);
    setcfg(1, 1'b1);
    m.start();
    fork
      m.xfer(8'ha4, 1'b1, rx, ack);
      begin
        wait_ev();
        chk(aph, 1'b1);
        chk(rel, 1'b0);
        strobe(3, 8'h00);
        strobe(1, 8'h00);
      end
    join
    chk(ack, 1'b0);
    wait_ev();
    chk(aph, 1'b0);
    fork
      m.xfer(8'h77, 1'b1, rx, ack);
      begin
        wait_ev();
        chk(rel, 1'b0);
        setcfg(4, 1'b1);
        strobe(3, 8'h00);
        strobe(1, 8'h00);
      end
    join
    chk(ack, 1'b1);
    settle();
    chk(flag, 1'b0);
    m.stop();
    @(posedge clk);
    cfg <= '0;
    strobe(6, 8'h00);
  endtask

  task automatic t_read(input logic coll_en);
    setcfg(5, coll_en);
    strobe(2, 8'hee);
    chk(bf, 1'b0);
    m.start();
    m.xfer(8'ha5, 1'b1, rx, ack);
    chk(ack, 1'b0);
    wait_ev();
    chk(rw, 1'b1);
    chk(rdata, 8'ha5);
    chk(rel, 1'b0);
    strobe(3, 8'h00);
    if (coll_en) begin
      strobe(2, 8'hff);
      strobe(1, 8'h00);
      m.xfer(8'h00, 1'b1, rx, ack);
      chk(coll, 1'b1);
      chk(sda_oe, 1'b0);
      strobe(7, 8'h00);
      chk(coll, 1'b0);
      // The refused-out byte never reaches a ninth fall, so software empties the buffer itself.
      strobe(3, 8'h00);
      chk(bf, 1'b0);
    end else begin
      tx(8'h96, 1'b0);
      chk(rack, 1'b0);
      chk(rel, 1'b0);
      tx(8'h3c, 1'b1);
      chk(rack, 1'b1);
      chk(rel, 1'b1);
    end
    m.stop();
    setcfg(5, 1'b0);
    strobe(0, 8'h00);
    strobe(6, 8'h00);
  endtask

  task automatic t_ten();
    setcfg(3, 1'b1);
    setcfg(2, 1'b1);
    strobe(4, 8'hf2);
    m.start();
    m.xfer(8'hf2, 1'b1, rx, ack);
    chk(ack, 1'b0);
    wait_ev();
    chk(ua, 1'b1);
    chk(scl_oe, 1'b1);
    strobe(3, 8'h00);
    strobe(4, 8'h5a);
    chk(ua, 1'b0);
    strobe(1, 8'h00);
    m.xfer(8'h5a, 1'b1, rx, ack);
    chk(ack, 1'b0);
    wait_ev();
    chk(ua, 1'b1);
    strobe(3, 8'h00);
    strobe(4, 8'hf2);
    strobe(1, 8'h00);
    m.xfer(8'h33, 1'b1, rx, ack);
    wait_ev();
    chk(rel, 1'b0);
    chk(rdata, 8'h33);
    strobe(3, 8'h00);
    strobe(1, 8'h00);
    m.stop();
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cfg = '0;
    stb = '0;
    wdat = '0;
    repeat (2) @(posedge link_clk);
    rst_n <= 1'b1;
    #1;
    chk(rel, 1'b1);
    chk({flag, bf, scl_oe, sda_oe}, 8'h00);
    strobe(4, 8'ha4);
    settle();
    t_write();
    t_hold();
    t_read(1'b0);
    t_read(1'b1);
    t_ten();
    results();
  end
endmodule
`default_nettype wire
